// file: logic/tbo_consts.vh
`ifndef TBO_CONSTS_VH
`define TBO_CONSTS_VH

// ==================================================
// register offsets (byte addresses)
`define TBO_AW            8
`define TBO_OFS_CTRL1     8'h00
`define TBO_OFS_CTRL2     8'h04
`define TBO_OFS_CMODE     8'h18
`define TBO_OFS_CHEN      8'h20
`define TBO_OFS_BDT       8'h44
`define TBO_OFS_DCTRL     8'h48
`define TBO_OFS_DMADDR    8'h4C
`define TBO_OFS_DAUX      8'h50

// ==================================================
// brake_deadtime_control fields
`define TBO_BDT_DTS_HI    7
`define TBO_BDT_LOCK_HI   9
`define TBO_BDT_LOCK_LO   8
`define TBO_BDT_IDLE_OSS  10
`define TBO_BDT_RUN_OSS   11
`define TBO_BDT_BRK_EN    12
`define TBO_BDT_BRK_POL   13
`define TBO_BDT_AUTO_OE   14
`define TBO_BDT_MAIN_OE   15

// ==================================================
// burst_dma_control fields
`define TBO_DC_BASE_HI    4
`define TBO_DC_LEN_HI     12
`define TBO_DC_LEN_LO     8

// ==================================================
// lock levels
`define TBO_LOCK_NONE     2'h0
`define TBO_LOCK_L1       2'h1
`define TBO_LOCK_L2       2'h2
`define TBO_LOCK_L3       2'h3

// ==================================================
// other fields and reset values
`define TBO_CHEN_POL_MASK 16'hAAAA
`define TBO_IDLE_LO       8
`define TBO_RST16         16'h0000
`define TBO_NCH           4

`endif

// file: logic/tbo_chan_out.v
`timescale 1ns/100ps

module tbo_chan_out (
  input  wire clk_sys,
  input  wire rst,
  input  wire main_oe,
  input  wire idle_oss,
  input  wire run_oss,
  input  wire chan_en,
  input  wire comp_en,
  input  wire pol,
  input  wire npol,
  input  wire idle_lvl,
  input  wire nidle_lvl,
  input  wire ref_lvl,
  output reg  oc_r,
  output reg  oc_oe_r,
  output reg  ocn_r,
  output reg  ocn_oe_r
);

  // ==================================================
  // enable edge tracking
  reg en_d_r;
  reg inact_r;
  wire en_rise = chan_en & ~en_d_r;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      en_d_r  <= 1'b0;
      inact_r <= 1'b0;
    end
    else
    begin
      en_d_r  <= chan_en;
      inact_r <= en_rise;
    end
  end

  // ==================================================
  // output gating
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      oc_r     <= 1'b0;
      oc_oe_r  <= 1'b0;
      ocn_r    <= 1'b0;
      ocn_oe_r <= 1'b0;
    end
    else if (main_oe)
    begin
      // run mode: enabled outputs follow the reference
      oc_oe_r  <= chan_en | run_oss;
      ocn_oe_r <= comp_en | run_oss;
      oc_r     <= chan_en ? (ref_lvl ^ pol) : pol;
      ocn_r    <= comp_en ? (~ref_lvl ^ npol) : npol;
    end
    else
    begin
      // idle mode: two inactive cycles stand in for the dead time
      oc_oe_r  <= idle_oss;
      ocn_oe_r <= idle_oss;
      oc_r     <= (en_rise | inact_r) ? pol : idle_lvl;
      ocn_r    <= (en_rise | inact_r) ? npol : nidle_lvl;
    end
  end

endmodule // tbo_chan_out

// file: logic/tbo_brake_dma.v
`timescale 1ns/100ps
`include "tbo_consts.vh"

module tbo_brake_dma (
  input  wire                    clk_sys,
  input  wire                    rst,
  input  wire [`TBO_AW-1:0]      bus_addr,
  input  wire [15:0]             bus_wdata,
  input  wire                    bus_wr,
  input  wire                    bus_rd,
  output reg  [15:0]             bus_rdata,
  input  wire                    brake_input,
  input  wire                    update_evt,
  input  wire [`TBO_NCH-1:0]     compare_ref,
  output reg                     main_output_enable,
  output reg  [1:0]              lock_level,
  output reg  [7:0]              dead_time_setup,
  output reg  [15:0]             compare_mode_cfg,
  output reg  [4:0]              burst_index,
  output reg  [`TBO_AW-1:0]      burst_target_addr,
  output wire [`TBO_NCH-1:0]     compare_output,
  output wire [`TBO_NCH-1:0]     compare_output_oe,
  output wire [`TBO_NCH-1:0]     complementary_compare_output,
  output wire [`TBO_NCH-1:0]     complementary_compare_output_oe
);

  // ==================================================
  // register state
  reg        lock_done_r;
  reg        idle_off_state_select_r;
  reg        run_off_state_select_r;
  reg        brake_function_enable_r;
  reg        brake_active_polarity_r;
  reg        automatic_output_enable_r;
  reg [7:0]  idle_levels_r;
  reg [15:0] chan_ctrl_r;
  reg [4:0]  burst_base_offset_r;
  reg [4:0]  burst_length_r;
  reg        byte_mode_r;
  reg [7:0]  byte_hold_r;
  reg        brk_s1_r;
  reg        brk_s2_r;
  reg [15:0] rdata_nxt;

  // ==================================================
  // lock decode
  wire lock_l1 = (lock_level != `TBO_LOCK_NONE);
  wire lock_l2 = lock_level[1];
  wire lock_l3 = (lock_level == `TBO_LOCK_L3);

  // ==================================================
  // burst redirection
  wire                is_burst  = (bus_addr == `TBO_OFS_DMADDR);
  wire                burst_acc = is_burst & (bus_wr | bus_rd);
  wire [5:0]          slot      = {1'b0, burst_base_offset_r} + {1'b0, burst_index};
  wire [`TBO_AW-1:0]  tgt_addr  = `TBO_OFS_CTRL1 + {slot, 2'b00};
  // a burst aimed at the burst register itself would recurse, so drop it
  wire                tgt_ok    = (tgt_addr != `TBO_OFS_DMADDR);
  wire [`TBO_AW-1:0]  eff_addr  = is_burst ? tgt_addr : bus_addr;
  wire                eff_wr    = bus_wr & (~is_burst | tgt_ok);
  wire                eff_rd    = bus_rd & (~is_burst | tgt_ok);
  wire [15:0]         byte_data = burst_index[0] ? {8'h00, byte_hold_r}
                                                 : {8'h00, bus_wdata[15:8]};
  wire [15:0]         eff_wdata = (is_burst & byte_mode_r) ? byte_data : bus_wdata;

  function wr_hit;
    input [`TBO_AW-1:0] ofs;
    begin
      wr_hit = eff_wr & (eff_addr == ofs);
    end
  endfunction

  wire bdt_wr = wr_hit(`TBO_OFS_BDT);

  // ==================================================
  // brake input
  // pin is synchronised for the auto enable path only;
  // the clear path acts on the raw pin on purpose
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      brk_s1_r <= 1'b0;
      brk_s2_r <= 1'b0;
    end
    else
    begin
      brk_s1_r <= brake_input;
      brk_s2_r <= brk_s1_r;
    end
  end

  wire brake_sync = brake_function_enable_r
                  & ~(brk_s2_r ^ brake_active_polarity_r);
  wire brake_clr  = brake_function_enable_r
                  & ~(brake_input ^ brake_active_polarity_r);

  // ==================================================
  // main output enable
  always @(posedge clk_sys or posedge brake_clr)
  begin
    if (brake_clr)
      main_output_enable <= 1'b0;
    else if (rst)
      main_output_enable <= 1'b0;
    else if (automatic_output_enable_r & update_evt & ~brake_sync)
      main_output_enable <= 1'b1;
    else if (bdt_wr)
      main_output_enable <= eff_wdata[`TBO_BDT_MAIN_OE];
  end

  // ==================================================
  // brake_deadtime_control
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      lock_level                <= `TBO_LOCK_NONE;
      lock_done_r               <= 1'b0;
      dead_time_setup           <= 8'h00;
      idle_off_state_select_r   <= 1'b0;
      run_off_state_select_r    <= 1'b0;
      brake_function_enable_r   <= 1'b0;
      brake_active_polarity_r   <= 1'b0;
      automatic_output_enable_r <= 1'b0;
    end
    else if (bdt_wr)
    begin
      lock_done_r <= 1'b1;
      if (!lock_done_r)
        lock_level <= eff_wdata[`TBO_BDT_LOCK_HI:`TBO_BDT_LOCK_LO];
      if (!lock_l1)
      begin
        dead_time_setup           <= eff_wdata[`TBO_BDT_DTS_HI:0];
        brake_function_enable_r   <= eff_wdata[`TBO_BDT_BRK_EN];
        brake_active_polarity_r   <= eff_wdata[`TBO_BDT_BRK_POL];
        automatic_output_enable_r <= eff_wdata[`TBO_BDT_AUTO_OE];
      end
      if (!lock_l2)
      begin
        idle_off_state_select_r <= eff_wdata[`TBO_BDT_IDLE_OSS];
        run_off_state_select_r  <= eff_wdata[`TBO_BDT_RUN_OSS];
      end
    end
  end

  // ==================================================
  // channel, compare mode and idle level registers
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      chan_ctrl_r      <= `TBO_RST16;
      compare_mode_cfg <= `TBO_RST16;
      idle_levels_r    <= 8'h00;
    end
    else
    begin
      if (wr_hit(`TBO_OFS_CHEN))
      begin
        // polarity bits freeze at level 2, enables stay writable
        if (lock_l2)
          chan_ctrl_r <= (chan_ctrl_r & `TBO_CHEN_POL_MASK)
                       | (eff_wdata & ~`TBO_CHEN_POL_MASK);
        else
          chan_ctrl_r <= eff_wdata;
      end
      if (wr_hit(`TBO_OFS_CMODE) && !lock_l3)
        compare_mode_cfg <= eff_wdata;
      if (wr_hit(`TBO_OFS_CTRL2) && !lock_l1)
        idle_levels_r <= eff_wdata[15:`TBO_IDLE_LO];
    end
  end

  // ==================================================
  // burst_dma_control and burst options
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      burst_base_offset_r <= 5'h00;
      burst_length_r      <= 5'h00;
      byte_mode_r         <= 1'b0;
    end
    else
    begin
      if (wr_hit(`TBO_OFS_DCTRL))
      begin
        burst_base_offset_r <= eff_wdata[`TBO_DC_BASE_HI:0];
        burst_length_r      <= eff_wdata[`TBO_DC_LEN_HI:`TBO_DC_LEN_LO];
      end
      if (wr_hit(`TBO_OFS_DAUX))
        byte_mode_r <= eff_wdata[0];
    end
  end

  // ==================================================
  // burst index and byte pairing
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      burst_index       <= 5'h00;
      burst_target_addr <= `TBO_OFS_CTRL1;
      byte_hold_r       <= 8'h00;
    end
    else if (burst_acc)
    begin
      burst_target_addr <= tgt_addr;
      if (burst_index == burst_length_r)
        burst_index <= 5'h00;
      else
        burst_index <= burst_index + 5'h01;
      if (bus_wr && !burst_index[0])
        byte_hold_r <= bus_wdata[7:0];
    end
    else if (bus_wr && bus_addr == `TBO_OFS_DCTRL)
      burst_index <= 5'h00;
  end

  // ==================================================
  // read path
  always @*
  begin
    rdata_nxt = `TBO_RST16;
    case (eff_addr)
      `TBO_OFS_BDT:
        rdata_nxt = {main_output_enable, automatic_output_enable_r,
                     brake_active_polarity_r, brake_function_enable_r,
                     run_off_state_select_r, idle_off_state_select_r,
                     lock_level, dead_time_setup};
      `TBO_OFS_DCTRL:
        rdata_nxt = {3'h0, burst_length_r, 3'h0, burst_base_offset_r};
      `TBO_OFS_CHEN:
        rdata_nxt = chan_ctrl_r;
      `TBO_OFS_CMODE:
        rdata_nxt = compare_mode_cfg;
      `TBO_OFS_CTRL2:
        rdata_nxt = {idle_levels_r, 8'h00};
      `TBO_OFS_DAUX:
        rdata_nxt = {15'h0000, byte_mode_r};
      default:
        rdata_nxt = `TBO_RST16;
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (rst)
      bus_rdata <= `TBO_RST16;
    else if (eff_rd)
    begin
      // byte bursts hand back only the low byte of each target
      if (is_burst & byte_mode_r)
        bus_rdata <= {8'h00, rdata_nxt[7:0]};
      else
        bus_rdata <= rdata_nxt;
    end
    else
      bus_rdata <= `TBO_RST16;
  end

  // ==================================================
  // compare output stages
  genvar ch;
  generate
    for (ch = 0; ch < `TBO_NCH; ch = ch + 1)
    begin : g_chan
      tbo_chan_out u_out (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .main_oe   (main_output_enable),
        .idle_oss  (idle_off_state_select_r),
        .run_oss   (run_off_state_select_r),
        .chan_en   (chan_ctrl_r[4*ch]),
        .comp_en   (chan_ctrl_r[4*ch+2]),
        .pol       (chan_ctrl_r[4*ch+1]),
        .npol      (chan_ctrl_r[4*ch+3]),
        .idle_lvl  (idle_levels_r[2*ch]),
        .nidle_lvl (idle_levels_r[2*ch+1]),
        .ref_lvl   (compare_ref[ch]),
        .oc_r      (compare_output[ch]),
        .oc_oe_r   (compare_output_oe[ch]),
        .ocn_r     (complementary_compare_output[ch]),
        .ocn_oe_r  (complementary_compare_output_oe[ch])
      );
    end
  endgenerate

endmodule // tbo_brake_dma

// file: sim/tbo_brake_dma_asserts.sv
`timescale 1ns/100ps
`include "tbo_consts.vh"

module tbo_brake_dma_asserts (
  input wire                clk_sys,
  input wire                rst,
  input wire [`TBO_AW-1:0]  bus_addr,
  input wire [15:0]         bus_wdata,
  input wire                bus_wr,
  input wire                bus_rd,
  input wire [15:0]         bus_rdata,
  input wire                update_evt,
  input wire                main_output_enable,
  input wire [1:0]          lock_level,
  input wire [4:0]          burst_index,
  input wire [`TBO_AW-1:0]  burst_target_addr
);
  // ==================================================
  // helpers
  reg        bdt_seen_r;
  reg  [4:0] base_r;

  // base mirrored from the bus, so redirection is checked without peeking inside
  always @(posedge clk_sys)
    if (rst)
      base_r <= 5'h00;
    else if (bus_wr && bus_addr == `TBO_OFS_DCTRL)
      base_r <= bus_wdata[4:0];

  always @(posedge clk_sys)
    if (rst)
      bdt_seen_r <= 1'b0;
    else if (bus_wr && bus_addr == `TBO_OFS_BDT)
      bdt_seen_r <= 1'b1;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ==================================================
  // properties
  sequence s_acc;
    (bus_wr || bus_rd) && bus_addr == `TBO_OFS_DMADDR;
  endsequence
  sequence s_dc_wr;
    bus_wr && bus_addr == `TBO_OFS_DCTRL;
  endsequence

  property p_rd_idle;
    !$past(bus_rd) |-> bus_rdata == 16'h0000;
  endproperty
  property p_dc_resv;
    bus_rd && bus_addr == `TBO_OFS_DCTRL |=> (bus_rdata & 16'hE0E0) == 16'h0000;
  endproperty
  property p_lock_once;
    $past(bdt_seen_r) |-> $stable(lock_level);
  endproperty
  property p_lock_src;
    $changed(lock_level) |-> $past(bus_wr && bus_addr == `TBO_OFS_BDT);
  endproperty
  property p_idx_clr;
    s_dc_wr |=> burst_index == 5'h00;
  endproperty
  property p_idx_src;
    $changed(burst_index) |-> $past((bus_wr || bus_rd) && bus_addr == `TBO_OFS_DMADDR
      || bus_wr && bus_addr == `TBO_OFS_DCTRL);
  endproperty
  property p_tgt;
    s_acc |=> burst_target_addr == (({3'h0, base_r} + {3'h0, $past(burst_index)}) << 2);
  endproperty
  property p_moe_rise;
    $rose(main_output_enable) |->
      $past(bus_wr && bus_addr == `TBO_OFS_BDT && bus_wdata[15] || update_evt);
  endproperty

  a_rd_idle:   assert property (p_rd_idle) else $error("read data outside read slot");
  a_dc_resv:   assert property (p_dc_resv) else $error("reserved burst bits set");
  a_lock_once: assert property (p_lock_once) else $error("lock level rewritten");
  a_lock_src:  assert property (p_lock_src) else $error("lock changed without write");
  a_idx_clr:   assert property (p_idx_clr) else $error("index not cleared");
  a_idx_src:   assert property (p_idx_src) else $error("index moved unprompted");
  a_tgt:       assert property (p_tgt) else $error("wrong burst target");
  a_moe_rise:  assert property (p_moe_rise) else $error("main enable set unprompted");
endmodule // tbo_brake_dma_asserts

// file: sim/tbo_bus_master.sv
`timescale 1ns/100ps

module tbo_bus_master (
  input  wire        clk_sys,
  input  wire [15:0] bus_rdata,
  output reg  [7:0]  bus_addr,
  output reg  [15:0] bus_wdata,
  output reg         bus_wr,
  output reg         bus_rd
);
  initial
  begin
    bus_addr = 8'h00;
    bus_wdata = 16'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end

  // ==================================================
  // accesses, always a cycle apart so a polarity write settles first
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
      bus_addr <= ~a;
      bus_wdata <= ~d;
      #1;
    end
  endtask

  task rd(input [7:0] a, output [15:0] d);
    begin
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      bus_addr <= ~a;
      #1;
      d = bus_rdata;
    end
  endtask
endmodule // tbo_bus_master

// file: sim/tb.sv
`timescale 1ns/100ps
`include "tbo_consts.vh"

module tb;
  reg         clk_sys;
  reg         rst;
  reg         brake_input;
  reg         update_evt;
  reg  [3:0]  compare_ref;
  wire [7:0]  bus_addr;
  wire [15:0] bus_wdata;
  wire        bus_wr;
  wire        bus_rd;
  wire [15:0] bus_rdata;
  wire        main_output_enable;
  wire [1:0]  lock_level;
  wire [15:0] compare_mode_cfg;
  wire [4:0]  burst_index;
  wire [7:0]  burst_target_addr;
  wire [3:0]  oc;
  wire [3:0]  oc_oe;
  wire [3:0]  ocn_oe;
  integer     n_fail, n_compared, cyc, i, j, base_m, len_m, idx_m;
  reg  [15:0] d, v;

  tbo_bus_master bm (.clk_sys(clk_sys), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd));

  tbo_brake_dma tbo_brake_dma_i (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .brake_input(brake_input), .update_evt(update_evt), .compare_ref(compare_ref),
    .main_output_enable(main_output_enable), .lock_level(lock_level),
    .dead_time_setup(), .compare_mode_cfg(compare_mode_cfg), .burst_index(burst_index),
    .burst_target_addr(burst_target_addr), .compare_output(oc), .compare_output_oe(oc_oe),
    .complementary_compare_output(), .complementary_compare_output_oe(ocn_oe));

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ==================================================
  // checking and closing
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        n_fail = n_fail + 1;
      end
    end
  endtask

  task stop_test;
    begin
      if (n_fail == 0 && n_compared > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  task do_reset;
    begin
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
    end
  endtask

  task pulse_update;
    begin
      @(posedge clk_sys);
      update_evt <= 1'b1;
      @(posedge clk_sys);
      update_evt <= 1'b0;
      #1;
    end
  endtask

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      stop_test;
    end
  end

  // ==================================================
  // scenarios
  initial
  begin
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    rst = 1'b1;
    brake_input = 1'b1;
    update_evt = 1'b0;
    v = $urandom(62);
    compare_ref = v[3:0];
    do_reset;
    bm.rd(`TBO_OFS_DCTRL, d);
    check(d, 16'h0000);
    for (i = 0; i < 4; i = i + 1)
    begin
      v = $urandom;
      bm.wr(`TBO_OFS_DCTRL, v);
      bm.rd(`TBO_OFS_DCTRL, d);
      check(d, v & 16'h1F1F);
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      base_m = (i == 0) ? 2 : (i == 1) ? 0 : $urandom % 4;
      len_m = (i == 0) ? 1 : (i == 1) ? 17 : (i == 2) ? 0 : 3;
      bm.wr(`TBO_OFS_DCTRL, {3'h0, len_m[4:0], 3'h0, base_m[4:0]});
      idx_m = 0;
      for (j = 0; j <= len_m + 1; j = j + 1)
      begin
        bm.rd(`TBO_OFS_DMADDR, d);
        check({8'h00, burst_target_addr}, 16'(4 * (base_m + idx_m)));
        idx_m = (idx_m == len_m) ? 0 : idx_m + 1;
        check({11'h000, burst_index}, 16'(idx_m));
      end
    end
    // byte burst: high byte lands first, reads give the low byte back
    bm.wr(`TBO_OFS_DAUX, 16'h0001);
    bm.wr(`TBO_OFS_DCTRL, 16'h0106);
    bm.wr(`TBO_OFS_DMADDR, 16'hA55A);
    bm.wr(`TBO_OFS_DMADDR, 16'hA55A);
    bm.rd(`TBO_OFS_CMODE, d);
    check(d, 16'h00A5);
    bm.wr(`TBO_OFS_DCTRL, 16'h0106);
    bm.rd(`TBO_OFS_DMADDR, d);
    check(d, 16'h00A5);
    bm.wr(`TBO_OFS_DAUX, 16'h0000);
    bm.wr(`TBO_OFS_BDT, 16'h1100);
    check({14'h0000, lock_level}, 16'h0001);
    bm.wr(`TBO_OFS_BDT, 16'hB300);
    check({14'h0000, lock_level}, 16'h0001);
    check({15'h0000, main_output_enable}, 16'h0001);
    bm.rd(`TBO_OFS_BDT, d);
    check(d & 16'h3000, 16'h1000);
    @(posedge clk_sys);
    brake_input <= 1'b0;
    #1;
    check({15'h0000, main_output_enable}, 16'h0000);
    @(posedge clk_sys);
    brake_input <= 1'b1;
    repeat (4) @(posedge clk_sys);
    pulse_update;
    check({15'h0000, main_output_enable}, 16'h0000);
    do_reset;
    check({14'h0000, lock_level}, 16'h0000);
    bm.wr(`TBO_OFS_CMODE, 16'h00FF);
    bm.wr(`TBO_OFS_BDT, 16'h5300);
    check({14'h0000, lock_level}, 16'h0003);
    repeat (4) @(posedge clk_sys);
    pulse_update;
    check({15'h0000, main_output_enable}, 16'h0001);
    bm.wr(`TBO_OFS_CMODE, 16'hFF00);
    check(compare_mode_cfg, 16'h00FF);
    bm.wr(`TBO_OFS_CHEN, 16'h0001);
    repeat (2) @(posedge clk_sys);
    #1;
    check({12'h000, oc_oe}, 16'h0001);
    check({15'h0000, oc[0]}, {15'h0000, compare_ref[0]});
    check({12'h000, ocn_oe}, 16'h0000);
    @(posedge clk_sys);
    brake_input <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({12'h000, oc_oe}, 16'h0000);
    stop_test;
  end
endmodule // tb

bind tbo_brake_dma tbo_brake_dma_asserts chk_i (.clk_sys(clk_sys), .rst(rst),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .update_evt(update_evt), .main_output_enable(main_output_enable),
  .lock_level(lock_level), .burst_index(burst_index), .burst_target_addr(burst_target_addr));
